// *** rtl/fdh_pkg.sv ***
// Package for the fixed drive host port: register selects, attachment
// control bit layout, FIFO sizing and the board-level select window.
// Assumes a single mclk domain at 10 MHz shared by both ends.
package fdh_pkg;
   // -----------------------------------------------------------------
   // Register selects (low address nibble)
   // -----------------------------------------------------------------
   localparam logic [3:0] FDH_SEL_DATA    = 4'h0;   // Data stream port
   localparam logic [3:0] FDH_SEL_STATUS  = 4'h1;   // Controller status
   localparam logic [3:0] FDH_SEL_ATTCTL  = 4'h2;   // Attachment control
   localparam logic [3:0] FDH_SEL_INTSTAT = 4'h3;   // Interrupt status
   // -----------------------------------------------------------------
   // Attachment control bits
   // -----------------------------------------------------------------
   localparam int FDH_ACB_DMA_EN = 0;
   localparam int FDH_ACB_IRQ_EN = 1;
   localparam logic [7:0] FDH_ATTCTL_RST = 8'h00;
   // Status bits
   localparam int FDH_STB_DATA_AVAIL = 0;
   localparam int FDH_STB_FIFO_FULL  = 1;
   localparam int FDH_STB_IRQ        = 2;
   // -----------------------------------------------------------------
   // Sizing and decode
   // -----------------------------------------------------------------
   localparam int FDH_DATA_W = 8;
   localparam int FDH_FIFO_DEPTH = 8;
   localparam logic [15:0] FDH_BASE_HI = 16'h0032;  // A19..A4 window
   localparam int FDH_WAIT_CYC = 2;                 // Wait states per access
   localparam int FDH_GAP_CYC = 4;                  // Host idle cycles between strobes
   localparam logic [7:0] FDH_ZERO8 = 8'h00;
endpackage

// *** rtl/fdh_bus_if.sv ***
// Interface carrying the I/O bus pins between host and fixed drive port.
// Assumes each end reads the other's data lines directly, with no shared bus to resolve.
`timescale 1ns/1ps
interface fdh_bus_if;
   logic [3:0] addr;       // Low address nibble
   logic [7:0] d_host;     // Data driven by host
   logic       d_host_oe;  // Host drives data
   logic [7:0] d_dev;      // Data driven by device
   logic       d_dev_oe;   // Device drives data
   logic       ior_n;
   logic       iow_n;
   logic       cs_n;
   logic       reset_drv;
   logic       irq;
   logic       drq;
   logic       dack_n;
   logic       chrdy;
   logic       installed_n;
   modport dev (
      input  addr, d_host, d_host_oe, ior_n, iow_n, cs_n, reset_drv, dack_n,
      output d_dev, d_dev_oe, irq, drq, chrdy, installed_n
   );
   modport host (
      input  d_dev, d_dev_oe, irq, drq, chrdy, installed_n,
      output addr, d_host, d_host_oe, ior_n, iow_n, cs_n, reset_drv, dack_n
   );
endinterface

// *** rtl/fdh_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; write and read may occur in the same cycle.
`timescale 1ns/1ps
module fdh_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp;
   logic [AW-1:0]    rp;
   logic [AW:0]      cnt;
   logic             push;
   logic             pop;

   // Honest full and empty from the occupancy count
   assign in_ready  = (cnt < (AW+1)'(DEPTH));   // Full only at DEPTH entries
   assign out_valid = (cnt != '0);
   assign out_data  = mem[rp];
   assign push      = ce && in_valid && in_ready;
   assign pop       = ce && out_valid && out_ready;

   // Storage
   always_ff @(posedge mclk)
   begin
      if (push)
         mem[wp] <= in_data;
   end

   // Pointers and count
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end
      else
      begin
         if (push)
            wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
         if (pop)
            rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
         if (push && !pop)
            cnt <= cnt + 1'b1;
         else if (pop && !push)
            cnt <= cnt - 1'b1;
      end
   end
endmodule // fdh_fifo

// *** rtl/fdh_dev.sv ***
// Fixed drive controller host port: register access by low address,
// wait-state insertion, IRQ and DMA request gated by attachment control.
// Assumes strobes arrive from pins and are synchronised here; the user
// side supplies drive data into a FIFO and receives written bytes.
`timescale 1ns/1ps
// What this block and fdh_host do
// - Low four address bits pick the register
// - Eight-bit bidirectional positive-logic data bus
// - Read strobe with select drives register data
// - Write strobe with select captures bus data
// - Reset holds; initialise after reset release
// - Raise interrupt after status becomes available
// - Interrupt only when attachment control enables
// - Drop channel ready to add wait states
// - DMA request held until acknowledge active
// - DMA request gated by attachment enable
// - Host acknowledges DMA only when requested
// - Board select decodes window 032x
// - Board select needs decode enable
// - Presence output held low when installed
module fdh_dev
   import fdh_pkg::*;
#(
   parameter int FIFO_DEPTH = FDH_FIFO_DEPTH
) (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       ce,
   fdh_bus_if.dev          bus,
   input  wire logic [7:0] usr_rd_data,
   input  wire logic       usr_rd_valid,
   output logic            usr_rd_ready,
   input  wire logic       usr_status_set,
   output logic [7:0]      usr_wr_data,
   output logic            usr_wr_valid,
   output logic [7:0]      usr_attctl
);
   typedef enum logic [1:0] {FDH_IDLE, FDH_WAIT, FDH_HOLD} fdh_acc_e;

   // -----------------------------------------------------------------
   // Pin synchronisers: three stages, accept when stages 2 and 3 agree
   // -----------------------------------------------------------------
   logic [2:0] s_ior, s_iow, s_cs, s_rst, s_dack;
   logic       ior_f, iow_f, cs_f, rst_f, dack_f;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_ior  <= 3'b111;
         s_iow  <= 3'b111;
         s_cs   <= 3'b111;
         s_dack <= 3'b111;
         s_rst  <= 3'b000;
      end
      else if (ce)
      begin
         s_ior  <= {s_ior[1:0], bus.ior_n};
         s_iow  <= {s_iow[1:0], bus.iow_n};
         s_cs   <= {s_cs[1:0], bus.cs_n};
         s_dack <= {s_dack[1:0], bus.dack_n};
         s_rst  <= {s_rst[1:0], bus.reset_drv};
      end
   end

   // Filtered levels change only on agreement of the late stages
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         ior_f  <= 1'b1;
         iow_f  <= 1'b1;
         cs_f   <= 1'b1;
         dack_f <= 1'b1;
         rst_f  <= 1'b0;
      end
      else if (ce)
      begin
         if (s_ior[1] == s_ior[2])   ior_f  <= s_ior[2];
         if (s_iow[1] == s_iow[2])   iow_f  <= s_iow[2];
         if (s_cs[1] == s_cs[2])     cs_f   <= s_cs[2];
         if (s_dack[1] == s_dack[2]) dack_f <= s_dack[2];
         if (s_rst[1] == s_rst[2])   rst_f  <= s_rst[2];
      end
   end

   // -----------------------------------------------------------------
   // Read data FIFO
   // -----------------------------------------------------------------
   logic [7:0] fq_data;
   logic       fq_valid;
   logic       fq_pop;

   fdh_fifo #(.WIDTH(FDH_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .rstn      (rstn),
      .ce        (ce && !rst_f),
      .in_data   (usr_rd_data),
      .in_valid  (usr_rd_valid),
      .in_ready  (usr_rd_ready),
      .out_data  (fq_data),
      .out_valid (fq_valid),
      .out_ready (fq_pop)
   );

   // -----------------------------------------------------------------
   // Access sequencer
   // -----------------------------------------------------------------
   fdh_acc_e   st;
   logic [1:0] wcnt;
   logic       rd_act, wr_act;
   logic       irq_pend;
   logic [3:0] asel;

   // A read of the data port via DMA or I/O is a cycle too
   assign rd_act = (!ior_f && !cs_f) || (!ior_f && !dack_f);
   assign wr_act = (!iow_f && !cs_f) || (!iow_f && !dack_f);
   assign asel   = dack_f ? bus.addr : FDH_SEL_DATA;
   assign fq_pop = ce && !rst_f && (st == FDH_WAIT) && (wcnt == '0) && rd_act
                   && (asel == FDH_SEL_DATA);

   // Wait states are counted before the cycle completes
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st   <= FDH_IDLE;
         wcnt <= '0;
      end
      else if (ce)
      begin
         if (rst_f)
            st <= FDH_IDLE;
         else
            case (st)
               FDH_IDLE:
                  if (rd_act || wr_act)
                  begin
                     st   <= FDH_WAIT;
                     wcnt <= 2'(FDH_WAIT_CYC - 1);
                  end
               FDH_WAIT:
                  if (wcnt == '0)
                     st <= FDH_HOLD;
                  else
                     wcnt <= wcnt - 1'b1;
               FDH_HOLD:
                  if (!rd_act && !wr_act)
                     st <= FDH_IDLE;
               default: st <= FDH_IDLE;
            endcase
      end
   end

   // Channel ready low while counting wait states
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         bus.chrdy <= 1'b1;
      else if (ce)
         bus.chrdy <= rst_f || !((st == FDH_IDLE && (rd_act || wr_act))
                      || (st == FDH_WAIT && wcnt != '0));
   end

   // Register writes and write stream out
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         usr_attctl   <= FDH_ATTCTL_RST;
         usr_wr_data  <= FDH_ZERO8;
         usr_wr_valid <= 1'b0;
      end
      else if (ce)
      begin
         usr_wr_valid <= 1'b0;
         if (rst_f)
            usr_attctl <= FDH_ATTCTL_RST;
         else if (st == FDH_WAIT && wcnt == '0 && wr_act && bus.d_host_oe)
         begin
            if (asel == FDH_SEL_ATTCTL)
               usr_attctl <= bus.d_host;
            else if (asel == FDH_SEL_DATA)
            begin
               usr_wr_data  <= bus.d_host;
               usr_wr_valid <= 1'b1;
            end
         end
      end
   end

   // Interrupt pending: status set wins over a clearing status read
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         irq_pend <= 1'b0;
      else if (ce)
      begin
         if (rst_f)
            irq_pend <= 1'b0;
         else if (usr_status_set)
            irq_pend <= 1'b1;
         else if (st == FDH_WAIT && wcnt == '0 && rd_act && asel == FDH_SEL_INTSTAT)
            irq_pend <= 1'b0;
      end
   end

   // Read data path onto the bus
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         bus.d_dev    <= FDH_ZERO8;
         bus.d_dev_oe <= 1'b0;
      end
      else if (ce)
      begin
         bus.d_dev_oe <= rd_act && !rst_f;
         if (st == FDH_WAIT && wcnt == '0 && rd_act)
            case (asel)
               FDH_SEL_DATA:    bus.d_dev <= fq_data;
               FDH_SEL_STATUS:  bus.d_dev <= {5'b0, irq_pend, !usr_rd_ready, fq_valid};
               FDH_SEL_ATTCTL:  bus.d_dev <= usr_attctl;
               FDH_SEL_INTSTAT: bus.d_dev <= {7'b0, irq_pend};
               default:         bus.d_dev <= FDH_ZERO8;
            endcase
      end
   end

   // Request lines: IRQ gated by enable, DRQ dropped on acknowledge
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         bus.irq <= 1'b0;
         bus.drq <= 1'b0;
      end
      else if (ce)
      begin
         bus.irq <= !rst_f && irq_pend && usr_attctl[FDH_ACB_IRQ_EN];
         bus.drq <= !rst_f && fq_valid && dack_f
                    && usr_attctl[FDH_ACB_DMA_EN];
      end
   end

   // Presence is a static active-low level
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         bus.installed_n <= 1'b0;
      else if (ce)
         bus.installed_n <= 1'b0;
   end
endmodule // fdh_dev

// *** rtl/fdh_host.sv ***
// System side of the fixed drive port: board select decode and a simple
// I/O cycle engine driving strobes, plus DMA acknowledge on request.
// Assumes device outputs are synchronous to the same mclk.
`timescale 1ns/1ps
module fdh_host
   import fdh_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        ce,
   fdh_bus_if.host          bus,
   input  wire logic        decode_en,
   input  wire logic [19:0] req_addr,
   input  wire logic        req_wr,
   input  wire logic [7:0]  req_wdata,
   input  wire logic        req_valid,
   output logic             req_ready,
   output logic [7:0]       rsp_data,
   output logic             rsp_valid,
   input  wire logic        dma_en,
   input  wire logic        drive_reset
);
   typedef enum logic [1:0] {FDH_H_IDLE, FDH_H_STROBE, FDH_H_END, FDH_H_GAP} fdh_host_e;
   fdh_host_e  st;
   logic       is_dma;
   logic       wait_seen;   // Port has stretched the current cycle
   logic [2:0] gap;         // Recovery count after a cycle

   // Window decode of A19..A4
   function automatic logic fdh_hit(input logic [19:0] a, input logic en);
      fdh_hit = en && (a[19:4] == FDH_BASE_HI);
   endfunction

   assign req_ready = (st == FDH_H_IDLE);

   // Cycle engine: strobe held until device releases channel ready
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st            <= FDH_H_IDLE;
         is_dma        <= 1'b0;
         wait_seen     <= 1'b0;
         gap           <= '0;
         bus.addr      <= '0;
         bus.d_host    <= FDH_ZERO8;
         bus.d_host_oe <= 1'b0;
         bus.ior_n     <= 1'b1;
         bus.iow_n     <= 1'b1;
         bus.cs_n      <= 1'b1;
         bus.dack_n    <= 1'b1;
         bus.reset_drv <= 1'b0;
         rsp_data      <= FDH_ZERO8;
         rsp_valid     <= 1'b0;
      end
      else if (ce)
      begin
         bus.reset_drv <= drive_reset;
         rsp_valid     <= 1'b0;
         case (st)
            FDH_H_IDLE:
               if (bus.drq && dma_en)
               begin
                  bus.dack_n <= 1'b0;
                  bus.ior_n  <= 1'b0;
                  is_dma     <= 1'b1;
                  st         <= FDH_H_STROBE;
               end
               else if (req_valid)
               begin
                  bus.addr      <= req_addr[3:0];
                  bus.cs_n      <= !fdh_hit(req_addr, decode_en);
                  bus.ior_n     <= req_wr;
                  bus.iow_n     <= !req_wr;
                  bus.d_host    <= req_wdata;
                  bus.d_host_oe <= req_wr;
                  is_dma        <= 1'b0;
                  st            <= FDH_H_STROBE;
               end
            FDH_H_STROBE:
               // Unselected cycle: nobody answers, so end it at once
               if (bus.cs_n && !is_dma)
                  st <= FDH_H_END;
               // Ready counts only after the port has stretched the cycle,
               // since its strobe filters lag the pins by several clocks
               else if (!bus.chrdy)
                  wait_seen <= 1'b1;
               else if (wait_seen)
                  st <= FDH_H_END;
            FDH_H_END:
            begin
               rsp_data      <= bus.d_dev;
               rsp_valid     <= !bus.ior_n;
               bus.ior_n     <= 1'b1;
               bus.iow_n     <= 1'b1;
               bus.cs_n      <= 1'b1;
               bus.dack_n    <= 1'b1;
               bus.d_host_oe <= 1'b0;
               wait_seen     <= 1'b0;
               gap           <= 3'(FDH_GAP_CYC - 1);
               st            <= FDH_H_GAP;
            end
            FDH_H_GAP:
               // Strobes stay high long enough for the port to see the end
               if (gap == '0)
                  st <= FDH_H_IDLE;
               else
                  gap <= gap - 1'b1;
            default: st <= FDH_H_IDLE;
         endcase
      end
   end
endmodule // fdh_host

// *** verification/fdh_bus_properties.sv ***
// Concurrent checks on the wires joining the host engine and the port.
// Assumes one mclk domain and the async active-low rstn of the bench.
`timescale 1ns/1ps
module fdh_bus_properties (
   input wire logic       mclk,
   input wire logic       rstn,
   input wire logic       ior_n,
   input wire logic       iow_n,
   input wire logic       cs_n,
   input wire logic       reset_drv,
   input wire logic       irq,
   input wire logic       drq,
   input wire logic       dack_n,
   input wire logic       chrdy,
   input wire logic       installed_n,
   input wire logic [7:0] d_dev,
   input wire logic       d_dev_oe
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // ---------------------------------------------------------------
   // Wait states and strobes
   // ---------------------------------------------------------------
   wait_len_a: assert property ($fell(chrdy) |-> ##1 !chrdy ##1 chrdy)
      else $error("wait state length wrong");
   wait_cause_a: assert property ($fell(chrdy) |-> (!ior_n || !iow_n) && (!cs_n || !dack_n))
      else $error("wait state without a selected cycle");
   strobe_hold_a: assert property ($rose(ior_n) || $rose(iow_n) |-> $past(chrdy))
      else $error("strobe dropped during wait state");
   // Read data must be on the bus when the wait ends, and gone later
   read_drive_a: assert property ($rose(chrdy) && !ior_n && !cs_n |-> d_dev_oe)
      else $error("read data not driven at end of wait");
   read_release_a: assert property (ior_n [*6] |-> !d_dev_oe)
      else $error("data bus driven with no read");
   read_stable_a: assert property (d_dev_oe && $past(d_dev_oe) && !ior_n && chrdy
      && $past(chrdy) |-> $stable(d_dev))
      else $error("read data moved during strobe");
   // ---------------------------------------------------------------
   // Requests, presence and reset
   // ---------------------------------------------------------------
   drq_hold_a: assert property ($fell(drq) |-> !dack_n || !$past(dack_n) || reset_drv)
      else $error("transfer request dropped before acknowledge");
   dack_req_a: assert property ($fell(dack_n) |-> $past(drq) || $past(drq, 2))
      else $error("acknowledge without a request");
   present_low_a: assert property (1'b1 |-> !installed_n)
      else $error("presence output not asserted");
   reset_idle_a: assert property (reset_drv [*6] |-> !irq && !drq && chrdy)
      else $error("request or stall during drive reset");
endmodule // fdh_bus_properties

// *** verification/tb_fixed_drive_host_io_port.sv ***
// Self-checking bench: host engine and port joined by the bus interface.
// Assumes the design package and both ends compiled before this file.
`timescale 1ns/1ps
module tb_fixed_drive_host_io_port;
   import fdh_pkg::*;
   logic        mclk;
   logic        rstn;
   logic        ce;
   logic        decode_en;
   logic        dma_en;
   logic        drive_reset;
   logic [19:0] req_addr;
   logic        req_wr;
   logic [7:0]  req_wdata;
   logic        req_valid;
   logic        req_ready;
   logic [7:0]  rsp_data;
   logic        rsp_valid;
   logic [7:0]  usr_rd_data;
   logic        usr_rd_valid;
   logic        usr_rd_ready;
   logic        usr_status_set;
   logic [7:0]  usr_wr_data;
   logic        usr_wr_valid;
   logic [7:0]  usr_attctl;
   logic [7:0]  rd;
   logic [7:0]  last_wr;
   int          wr_cnt;
   int          cs_cnt;
   int          fail_count;
   int          n_compared;
   fdh_bus_if bus ();
   fdh_dev fdh_dev_i (.mclk(mclk), .rstn(rstn), .ce(ce), .bus(bus),
      .usr_rd_data(usr_rd_data), .usr_rd_valid(usr_rd_valid), .usr_rd_ready(usr_rd_ready),
      .usr_status_set(usr_status_set), .usr_wr_data(usr_wr_data),
      .usr_wr_valid(usr_wr_valid), .usr_attctl(usr_attctl));
   fdh_host fdh_host_i (.mclk(mclk), .rstn(rstn), .ce(ce), .bus(bus),
      .decode_en(decode_en), .req_addr(req_addr), .req_wr(req_wr), .req_wdata(req_wdata),
      .req_valid(req_valid), .req_ready(req_ready), .rsp_data(rsp_data),
      .rsp_valid(rsp_valid), .dma_en(dma_en), .drive_reset(drive_reset));
   fdh_bus_properties fdh_bus_properties_i (.mclk(mclk), .rstn(rstn), .ior_n(bus.ior_n),
      .iow_n(bus.iow_n), .cs_n(bus.cs_n), .reset_drv(bus.reset_drv), .irq(bus.irq),
      .drq(bus.drq), .dack_n(bus.dack_n), .chrdy(bus.chrdy), .installed_n(bus.installed_n),
      .d_dev(bus.d_dev), .d_dev_oe(bus.d_dev_oe));
   // 100 ns clock
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Record bytes written to the data port and cycles with the select low
   always @(posedge mclk)
   begin
      if (usr_wr_valid === 1'b1)
      begin
         last_wr <= usr_wr_data;
         wr_cnt  <= wr_cnt + 1;
      end
      if (bus.cs_n === 1'b0)
         cs_cnt <= cs_cnt + 1;
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   task automatic close_out;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   // A limit that runs out ends the run straight away
   task automatic give_up(input string msg);
      check(1'b0, msg);
      close_out;
   endtask
   function automatic logic [19:0] ha(input logic [3:0] sel);
      return {FDH_BASE_HI, sel};
   endfunction
   // One host cycle; waits for idle, then for read data or for idle again
   task automatic io(input logic [19:0] a, input logic wr, input logic [7:0] wd);
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 80) begin step(1); k++; end
      if (k >= 80) give_up("host engine stuck busy");
      req_addr  = a;
      req_wr    = wr;
      req_wdata = wd;
      req_valid = 1'b1;
      // A transfer request may win the engine first; hold ours until taken
      for (k = 0; k < 80; k++)
      begin
         step(1);
         if ((bus.ior_n === 1'b0 || bus.iow_n === 1'b0) && bus.dack_n === 1'b1) break;
      end
      req_valid = 1'b0;
      if (k >= 80) give_up("host never took the request");
      for (k = 0; k < 80; k++)
      begin
         step(1);
         if (!wr && rsp_valid === 1'b1) break;
         if (wr && req_ready === 1'b1) break;
      end
      rd = rsp_data;
      if (k >= 80) give_up("host cycle never completed");
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      check(bus.irq === 1'b0 && bus.drq === 1'b0 && bus.chrdy === 1'b1, "idle after reset");
      check(bus.installed_n === 1'b0, "presence not asserted");
      check(usr_attctl === FDH_ATTCTL_RST, "control not cleared");
   endtask
   task automatic t_regs;
      io(ha(FDH_SEL_ATTCTL), 1'b1, 8'h03);
      check(usr_attctl === 8'h03, "control write lost");
      io(ha(FDH_SEL_ATTCTL), 1'b0, 8'h00);
      check(rd === 8'h03, "control readback");
      io(ha(FDH_SEL_DATA), 1'b1, 8'hA5);
      check(last_wr === 8'hA5 && wr_cnt == 1, "data port write");
      io(ha(4'hF), 1'b0, 8'h00);
      check(rd === 8'h00, "unmapped select not zero");
      io(ha(FDH_SEL_ATTCTL), 1'b1, 8'h00);
   endtask
   // Select stays off when decode is disabled or the window misses
   task automatic t_decode;
      cs_cnt    = 0;
      decode_en = 1'b0;
      io(ha(FDH_SEL_ATTCTL), 1'b1, 8'h02);
      decode_en = 1'b1;
      io({16'h0033, FDH_SEL_ATTCTL}, 1'b1, 8'h02);
      check(cs_cnt == 0 && usr_attctl === 8'h00, "select outside window");
   endtask
   task automatic t_irq;
      int k;
      usr_status_set = 1'b1;
      step(1);
      usr_status_set = 1'b0;
      step(10);
      check(bus.irq === 1'b0, "interrupt while disabled");
      io(ha(FDH_SEL_INTSTAT), 1'b0, 8'h00);
      io(ha(FDH_SEL_ATTCTL), 1'b1, 8'h02);
      usr_status_set = 1'b1;
      step(1);
      usr_status_set = 1'b0;
      for (k = 0; k < 20 && bus.irq !== 1'b1; k++) step(1);
      check(bus.irq === 1'b1, "no interrupt after status");
      io(ha(FDH_SEL_STATUS), 1'b0, 8'h00);
      check(rd[FDH_STB_IRQ] === 1'b1, "pending bit clear");
      io(ha(FDH_SEL_INTSTAT), 1'b0, 8'h00);
      step(4);
      check(bus.irq === 1'b0, "interrupt not cleared by read");
      io(ha(FDH_SEL_ATTCTL), 1'b1, 8'h00);
   endtask
   // Fill the buffer to refusal, drain by reads, then by transfer requests
   task automatic t_fifo;
      int k;
      for (k = 0; k < 8; k++)
      begin
         usr_rd_data  = 8'h10 + 8'(k);
         usr_rd_valid = 1'b1;
         check(usr_rd_ready === 1'b1, "buffer refused early");
         step(1);
      end
      check(usr_rd_ready === 1'b0, "buffer not full at depth");
      usr_rd_valid = 1'b0;
      check(bus.drq === 1'b0, "request while disabled");
      io(ha(FDH_SEL_STATUS), 1'b0, 8'h00);
      check(rd === 8'h03, "status with full buffer");
      for (k = 0; k < 3; k++)
      begin
         io(ha(FDH_SEL_DATA), 1'b0, 8'h00);
         check(rd === 8'h10 + 8'(k), "data order");
      end
      dma_en = 1'b1;
      io(ha(FDH_SEL_ATTCTL), 1'b1, 8'h01);
      for (k = 0; k < 30; k++)
      begin
         io(ha(FDH_SEL_STATUS), 1'b0, 8'h00);
         if (rd[FDH_STB_DATA_AVAIL] === 1'b0) break;
      end
      check(rd === 8'h00 && bus.drq === 1'b0, "transfers did not drain");
      io(ha(FDH_SEL_ATTCTL), 1'b1, 8'h00);
   endtask
   task automatic t_drvreset;
      io(ha(FDH_SEL_ATTCTL), 1'b1, 8'h03);
      drive_reset = 1'b1;
      step(10);
      check(bus.irq === 1'b0 && bus.drq === 1'b0, "requests during reset");
      drive_reset = 1'b0;
      step(10);
      check(usr_attctl === 8'h00, "control kept over reset");
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rstn = 1'b0; ce = 1'b1; decode_en = 1'b1; dma_en = 1'b0; drive_reset = 1'b0;
      req_addr = 20'h0_0000; req_wr = 1'b0; req_wdata = 8'h00; req_valid = 1'b0;
      usr_rd_data = 8'h00; usr_rd_valid = 1'b0; usr_status_set = 1'b0;
      fail_count = 0; n_compared = 0; wr_cnt = 0; cs_cnt = 0; last_wr = 8'h00;
      step(16);
      rstn = 1'b1;
      step(2);
      t_reset();
      t_regs();
      t_decode();
      t_irq();
      t_fifo();
      t_drvreset();
      // Second reset in mid-run, with the control register set
      io(ha(FDH_SEL_ATTCTL), 1'b1, 8'h03);
      rstn = 1'b0;
      step(3);
      t_reset();
      rstn = 1'b1;
      step(2);
      close_out;
   end
endmodule // tb_fixed_drive_host_io_port
